/* spcs_defines.vh */
// constants, register map and field layout of the serial port control block
// Overview of operation
// - tx-done irq requested while enabled; drops when done cleared or enable cleared
// - async clock select: 00 internal, 01 clock out, high bit x16 pin clock
// - sync mode: upper select 0 drives clock out, 1 takes pin clock in
// - tx-empty irq requested while enabled; cancelled by flag clear or enable clear
// - rx-full and rx-error irqs requested while rx irq enable is set
// - tx enable starts sending after holding write; disabled holds empty flag at 1
// - rx starts on start bit (async) or on clock input (sync)
// - clearing rx enable keeps rx flags, rx data and rx address bit
// - address wait skips frames with address bit 0, no flags set
// - frame with address bit 1 sets status bit and clears wait enable
// - smart card clock pin: guard mode selects low, high or clock output
// - status flags ignore 1 writes; clear only by 0 after reading 1
// - tx-empty resets 1, sets on disable or load, clears on clear or dma
// - rx-full sets on good frame, clears on software clear or dma read
// - overrun sets on frame while rx-full; old data kept; halts rx and sync tx
// - framing error on first stop 0; data stored, rx-full not set, halts rx
// - parity error stores data without rx-full; halts rx and sync tx
// - tx-done resets 1; sets on disable or empty at last bit; clears on reload
// - rx address bit captured per frame; tx address bit appended when sending
// - smart card select chooses smart card behaviour of the bits
`ifndef SPCS_DEFINES_VH
`define SPCS_DEFINES_VH
`define SPCS_ADDR_CTRL    2'h0
`define SPCS_ADDR_STAT    2'h1
`define SPCS_ADDR_TXDATA  2'h2
`define SPCS_ADDR_RXDATA  2'h3
`define SPCS_ADDR_MODE    2'h0
// control bits
`define SPCS_C_TIE   7
`define SPCS_C_RIE   6
`define SPCS_C_TE    5
`define SPCS_C_RE    4
`define SPCS_C_WAIT  3
`define SPCS_C_TX_DONE_IRQ_EN  2
`define SPCS_C_CK1   1
`define SPCS_C_CK0   0
// status bits
`define SPCS_S_TXE   7
`define SPCS_S_RXF   6
`define SPCS_S_OVR   5
`define SPCS_S_FER   4
`define SPCS_S_PER   3
`define SPCS_S_TXD   2
`define SPCS_S_RMP   1
`define SPCS_S_TMP   0
`define SPCS_CTRL_RST 8'h00
`define SPCS_STAT_RST 8'h84
// divider of clk_i giving the internal bit clock (cycles per bit)
`define SPCS_BIT_CYC  8'h10
// external clock is 16x bit rate in async mode
`define SPCS_OVS      5'h10
`endif

/* spcs_serial_port.v */
// serial port control, status, shifters and clock pin logic
`timescale 1ns/10ps
`include "spcs_defines.vh"
module spcs_serial_port (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [1:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    input  wire       sync_mode_i,
    input  wire       chr7_i,
    input  wire       par_en_i,
    input  wire       par_odd_i,
    input  wire       stop2_i,
    input  wire       mp_mode_i,
    input  wire       smartcard_select_i,
    input  wire       guard_clock_mode_i,
    input  wire       dma_tx_wr_i,
    input  wire [7:0] dma_tx_data_i,
    input  wire       dma_rx_rd_i,
    input  wire       rxd_i,
    output reg        txd_o,
    input  wire       sck_i,
    output reg        sck_o,
    output reg        sck_oe_o,
    output reg        tx_empty_irq_o,
    output reg        rx_full_irq_o,
    output reg        rx_error_irq_o,
    output reg        tx_done_irq_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_DATA = 2'h1;
    localparam ST_STOP = 2'h2;

    reg [7:0] ctrl_ff;
    reg [7:0] stat_ff;
    reg [4:0] seen_ff;           // flags read as 1 since last clear
    reg [7:0] tx_holding_reg_ff;
    reg [7:0] rx_holding_reg_ff;
    reg [1:0] rxd_s_ff;
    reg [1:0] sck_s_ff;
    reg       sck_d_ff;
    reg [7:0] bdiv_ff;
    reg       bclk_ff;
    reg [4:0] ovs_ff;
    // transmitter
    reg [1:0] tst_ff;
    reg [10:0] tx_shifter_ff;
    reg [3:0] tcnt_ff;
    // receiver
    reg [1:0] rst_st_ff;
    reg [10:0] rx_shifter_ff;
    reg [3:0] rcnt_ff;

    // two-flop synchronised pins; only the second flop is read
    wire rxd_w = rxd_s_ff[1];
    wire sck_w = sck_s_ff[1];
    wire sck_rise = sck_w & ~sck_d_ff;
    wire sck_fall = ~sck_w & sck_d_ff;
    wire sync_ext = sync_mode_i & ctrl_ff[`SPCS_C_CK1];
    wire async_ext = ~sync_mode_i & ctrl_ff[`SPCS_C_CK1];
    // any receive error halts reception; sync mode halts transmit too
    wire err_any = stat_ff[`SPCS_S_OVR] | stat_ff[`SPCS_S_FER]
                 | stat_ff[`SPCS_S_PER];
    wire tx_halt = sync_mode_i & err_any;

    // internal bit clock divider, one tick per bit
    wire bit_tick = (bdiv_ff == `SPCS_BIT_CYC - 8'h01);
    wire half_tick = (bdiv_ff == (`SPCS_BIT_CYC >> 1) - 8'h01);
    // tick source: internal, x16 pin clock, or sync pin clock edges
    wire ovs_tick = sck_rise & (ovs_ff == `SPCS_OVS - 5'h01);
    wire tx_tick = sync_mode_i ? (sync_ext ? sck_fall : bit_tick)
                 : (async_ext ? ovs_tick : bit_tick);
    wire rx_tick = sync_mode_i ? (sync_ext ? sck_rise : half_tick)
                 : (async_ext ? ovs_tick : bit_tick);

    // holding register moves to the shifter on a bit tick once cleared
    wire load_tx = (tst_ff == ST_IDLE) & ctrl_ff[`SPCS_C_TE]
                 & ~stat_ff[`SPCS_S_TXE] & ~tx_halt & tx_tick;
    // stop bit begins: the character's last bit has gone out
    wire last_bit = (tst_ff == ST_STOP) & tx_tick & (tcnt_ff == 4'h0);
    // frame length: data bits plus a parity or address bit
    wire [3:0] nbits = sync_mode_i ? 4'h8 : (chr7_i ? 4'h7 : 4'h8);
    wire xtra = ~sync_mode_i & (mp_mode_i | par_en_i);
    wire tpar = ^tx_holding_reg_ff[6:0] ^ par_odd_i
              ^ (chr7_i ? 1'b0 : tx_holding_reg_ff[7]);
    wire xbit = mp_mode_i ? stat_ff[`SPCS_S_TMP] : tpar;

    // received-frame decode
    wire rx_done = (rst_st_ff == ST_STOP) & rx_tick;
    // frames without an extra bit sit one place higher in the shifter;
    // aligned, data starts at bit 2 (bit 3 for 7-bit async frames) and the extra bit is bit 10
    wire [10:0] ralign = xtra ? rx_shifter_ff
                              : {1'b0, rx_shifter_ff[10:1]};
    wire [7:0] rdat = (chr7_i & ~sync_mode_i) ? {1'b0, ralign[9:3]}
                    : ralign[9:2];
    wire rx_xbit = ralign[10];
    wire rx_par_bad = par_en_i & ~mp_mode_i & ~sync_mode_i
        & ((^rdat) ^ rx_xbit ^ par_odd_i);
    wire skip = mp_mode_i & ~sync_mode_i & ctrl_ff[`SPCS_C_WAIT]
              & ~rx_xbit;
    wire stop_bad = ~sync_mode_i & ~rxd_w;

    // register strobes decoded per offset
    wire wr_ctrl = wr_i & (addr_i == `SPCS_ADDR_CTRL);
    wire wr_stat = wr_i & (addr_i == `SPCS_ADDR_STAT);
    wire wr_tdat = wr_i & (addr_i == `SPCS_ADDR_TXDATA);
    wire rd_stat = rd_i & (addr_i == `SPCS_ADDR_STAT);

    // pin synchronisers and bit clock
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rxd_s_ff <= 2'h3;
            sck_s_ff <= 2'h0;
            sck_d_ff <= 1'b0;
            bdiv_ff  <= 8'h00;
            bclk_ff  <= 1'b1;
            ovs_ff   <= 5'h00;
        end else begin
            rxd_s_ff <= {rxd_s_ff[0], rxd_i};
            sck_s_ff <= {sck_s_ff[0], sck_i};
            sck_d_ff <= sck_w;
            bdiv_ff  <= bit_tick ? 8'h00 : bdiv_ff + 8'h01;
            if (bit_tick)
                bclk_ff <= 1'b1;
            else if (half_tick)
                bclk_ff <= 1'b0;
            if (sck_rise)
                ovs_ff <= ovs_tick ? 5'h00 : ovs_ff + 5'h01;
        end
    end

    // clock pin function
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_o    <= 1'b0;
            sck_oe_o <= 1'b0;
        end else if (smartcard_select_i) begin
            sck_oe_o <= ctrl_ff[`SPCS_C_CK0] | guard_clock_mode_i;
            sck_o    <= ctrl_ff[`SPCS_C_CK0] ? bclk_ff
                      : (guard_clock_mode_i & ctrl_ff[`SPCS_C_CK1]);
        end else if (sync_mode_i) begin
            sck_oe_o <= ~ctrl_ff[`SPCS_C_CK1];
            sck_o    <= (tst_ff != ST_IDLE) ? bclk_ff : 1'b1;
        end else begin
            sck_oe_o <= ~ctrl_ff[`SPCS_C_CK1]
                      & ctrl_ff[`SPCS_C_CK0];
            sck_o    <= bclk_ff;
        end
    end

    // transmitter
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tst_ff        <= ST_IDLE;
            tx_shifter_ff <= 11'h7FF;
            tcnt_ff       <= 4'h0;
            txd_o         <= 1'b1;
        end else begin
            case (tst_ff)
                ST_IDLE: begin
                    txd_o <= 1'b1;
                    if (load_tx) begin
                        tst_ff  <= ST_DATA;
                        txd_o   <= sync_mode_i ? tx_holding_reg_ff[0] : 1'b0;
                        tx_shifter_ff <= {2'h3, xbit, tx_holding_reg_ff};
                        tcnt_ff <= sync_mode_i ? 4'h7 : nbits + {3'h0, xtra};
                    end
                end
                ST_DATA: begin
                    if (tx_tick) begin
                        if (sync_mode_i)
                            tx_shifter_ff <= {1'b1, tx_shifter_ff[10:1]};
                        if (tcnt_ff == 4'h1
                            || (sync_mode_i && tcnt_ff == 4'h0)) begin
                            tst_ff  <= ST_STOP;
                            tcnt_ff <= (sync_mode_i | ~stop2_i) ? 4'h0 : 4'h1;
                        end else
                            tcnt_ff <= tcnt_ff - 4'h1;
                        if (!sync_mode_i) begin
                            // 7-bit frames put the extra bit in data bit 7's slot
                            txd_o <= (chr7_i && xtra && tcnt_ff == 4'h1)
                                   ? xbit : tx_shifter_ff[0];
                            tx_shifter_ff <= {1'b1, tx_shifter_ff[10:1]};
                        end else
                            txd_o <= tx_shifter_ff[1];
                    end
                    if (!ctrl_ff[`SPCS_C_TE])
                        tst_ff <= ST_IDLE;
                end
                ST_STOP: begin
                    if (tx_tick) begin
                        txd_o <= 1'b1;
                        if (tcnt_ff == 4'h0)
                            tst_ff <= ST_IDLE;
                        else
                            tcnt_ff <= tcnt_ff - 4'h1;
                    end
                end
                default: tst_ff <= ST_IDLE;
            endcase
        end
    end

    // receiver
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_st_ff     <= ST_IDLE;
            rx_shifter_ff <= 11'h000;
            rcnt_ff       <= 4'h0;
        end else begin
            case (rst_st_ff)
                ST_IDLE: begin
                    // start bit or clock edge starts a frame, unless halted
                    if (ctrl_ff[`SPCS_C_RE] && !err_any &&
                        (sync_mode_i ? rx_tick : (!rxd_w && rx_tick))) begin
                        rst_st_ff <= ST_DATA;
                        rcnt_ff   <= sync_mode_i ? 4'h7 : nbits + {3'h0, xtra};
                        if (sync_mode_i)
                            rx_shifter_ff <= {rxd_w, rx_shifter_ff[10:1]};
                    end
                end
                ST_DATA: begin
                    if (rx_tick) begin
                        rx_shifter_ff <= {rxd_w, rx_shifter_ff[10:1]};
                        if (rcnt_ff == 4'h1)
                            rst_st_ff <= ST_STOP;
                        rcnt_ff <= rcnt_ff - 4'h1;
                    end
                end
                ST_STOP: begin
                    // stop bit is sampled here, judged in the status logic
                    if (rx_tick)
                        rst_st_ff <= ST_IDLE;
                end
                default: rst_st_ff <= ST_IDLE;
            endcase
        end
    end

    // control, status and data registers
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff           <= `SPCS_CTRL_RST;
            stat_ff           <= `SPCS_STAT_RST;
            seen_ff           <= 5'h00;
            tx_holding_reg_ff <= 8'h00;
            rx_holding_reg_ff <= 8'h00;
        end else begin
            if (wr_ctrl)
                ctrl_ff <= wdata_i;
            if (wr_tdat)
                tx_holding_reg_ff <= wdata_i;
            else if (dma_tx_wr_i)
                tx_holding_reg_ff <= dma_tx_data_i;
            // read-as-1 memory, forgotten once a flag drops
            if (rd_stat)
                seen_ff <= stat_ff[7:3];
            else if (wr_stat)
                seen_ff <= seen_ff & stat_ff[7:3] & wdata_i[7:3];
            else
                seen_ff <= seen_ff & stat_ff[7:3];
            // flags: 0 written after 1 read clears, 1 writes ignored; TMP takes the written value
            if (wr_stat) begin
                stat_ff[`SPCS_S_TMP] <= wdata_i[`SPCS_S_TMP];
                if (!wdata_i[`SPCS_S_TXE] && seen_ff[4]) begin
                    stat_ff[`SPCS_S_TXE] <= 1'b0;
                    stat_ff[`SPCS_S_TXD] <= 1'b0;
                end
                if (!wdata_i[`SPCS_S_RXF] && seen_ff[3])
                    stat_ff[`SPCS_S_RXF] <= 1'b0;
                if (!wdata_i[`SPCS_S_OVR] && seen_ff[2])
                    stat_ff[`SPCS_S_OVR] <= 1'b0;
                if (!wdata_i[`SPCS_S_FER] && seen_ff[1])
                    stat_ff[`SPCS_S_FER] <= 1'b0;
                if (!wdata_i[`SPCS_S_PER] && seen_ff[0])
                    stat_ff[`SPCS_S_PER] <= 1'b0;
            end
            if (dma_tx_wr_i && !wr_stat) begin
                stat_ff[`SPCS_S_TXE] <= 1'b0;
                stat_ff[`SPCS_S_TXD] <= 1'b0;
            end
            // dma read of received data empties the holding register
            if (dma_rx_rd_i)
                stat_ff[`SPCS_S_RXF] <= 1'b0;
            // hardware sets win over clears, placed last
            if (load_tx)
                stat_ff[`SPCS_S_TXE] <= 1'b1;
            if (!ctrl_ff[`SPCS_C_TE]) begin
                stat_ff[`SPCS_S_TXE] <= 1'b1;
                stat_ff[`SPCS_S_TXD] <= 1'b1;
            end
            if (last_bit && stat_ff[`SPCS_S_TXE])
                stat_ff[`SPCS_S_TXD] <= 1'b1;
            // frame end; rx enable low leaves all rx state alone
            if (rx_done && !skip) begin
                if (!sync_mode_i && mp_mode_i) begin
                    stat_ff[`SPCS_S_RMP] <= rx_xbit;
                    if (rx_xbit && !wr_ctrl)
                        ctrl_ff[`SPCS_C_WAIT] <= 1'b0;
                end
                if (stat_ff[`SPCS_S_RXF])
                    stat_ff[`SPCS_S_OVR] <= 1'b1;
                else if (stop_bad || rx_par_bad) begin
                    rx_holding_reg_ff <= rdat;
                    if (stop_bad)
                        stat_ff[`SPCS_S_FER] <= 1'b1;
                    if (rx_par_bad)
                        stat_ff[`SPCS_S_PER] <= 1'b1;
                end else begin
                    rx_holding_reg_ff <= rdat;
                    stat_ff[`SPCS_S_RXF] <= 1'b1;
                end
            end
        end
    end

    // read data and interrupt levels
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o        <= 8'h00;
            tx_empty_irq_o <= 1'b0;
            rx_full_irq_o  <= 1'b0;
            rx_error_irq_o <= 1'b0;
            tx_done_irq_o  <= 1'b0;
        end else begin
            rdata_o <= ~rd_i ? 8'h00
                     : (addr_i == `SPCS_ADDR_CTRL) ? ctrl_ff
                     : (addr_i == `SPCS_ADDR_STAT) ? stat_ff
                     : (addr_i == `SPCS_ADDR_TXDATA) ? tx_holding_reg_ff
                     : rx_holding_reg_ff;
            tx_empty_irq_o <= stat_ff[`SPCS_S_TXE]
                            & ctrl_ff[`SPCS_C_TIE];
            rx_full_irq_o  <= stat_ff[`SPCS_S_RXF]
                            & ctrl_ff[`SPCS_C_RIE];
            rx_error_irq_o <= err_any & ctrl_ff[`SPCS_C_RIE];
            tx_done_irq_o  <= stat_ff[`SPCS_S_TXD]
                            & ctrl_ff[`SPCS_C_TX_DONE_IRQ_EN];
        end
    end
endmodule

/* spcs_monitor.sv */
// checker of the serial port control outputs
`timescale 1ns/10ps
module spcs_monitor (
    input logic       clk_i,
    input logic       rst_i,
    input logic [1:0] addr_i,
    input logic [7:0] wdata_i,
    input logic       wr_i,
    input logic       rd_i,
    input logic [7:0] rdata_o,
    input logic       sync_mode_i,
    input logic       smartcard_select_i,
    input logic       guard_clock_mode_i,
    input logic       sck_o,
    input logic       sck_oe_o,
    input logic       tx_empty_irq_o,
    input logic       rx_full_irq_o,
    input logic       rx_error_irq_o,
    input logic       tx_done_irq_o
);
    logic [7:0] ctl_ff;
    wire        as = !sync_mode_i && !smartcard_select_i;
    wire  [1:0] ck = ctl_ff[1:0];
    // mirror of the control register
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_ff <= 8'h00;
        end else if (wr_i && addr_i == 2'h0) begin
            ctl_ff <= wdata_i;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // condition held over three cycles
    sequence s_held(c);
        c [*3];
    endsequence
    a_tie_off: assert property (
        s_held(!ctl_ff[7]) |-> !tx_empty_irq_o) else $error("txe irq on");
    a_rie_off: assert property (
        s_held(!ctl_ff[6]) |-> !(rx_full_irq_o || rx_error_irq_o))
        else $error("rx irq on");
    a_tx_done_irq_en_off: assert property (
        s_held(!ctl_ff[2]) |-> !tx_done_irq_o) else $error("done irq on");
    a_txe_fixed: assert property (
        s_held(ctl_ff[7] && !ctl_ff[5]) |-> tx_empty_irq_o)
        else $error("txe not held");
    a_done_fixed: assert property (
        s_held(ctl_ff[2] && !ctl_ff[5]) |-> tx_done_irq_o)
        else $error("done not held");
    a_status_read: assert property (
        rd_i && addr_i == 2'h1 && !ctl_ff[5] && !$past(ctl_ff[5])
        |=> rdata_o[7] && rdata_o[2]) else $error("flags not 1");
    a_ck_port: assert property (
        s_held(as && ck == 2'h0) |-> !sck_oe_o) else $error("pin driven");
    a_ck_out: assert property (
        s_held(as && ck == 2'h1) |-> sck_oe_o) else $error("no clock out");
    a_ck_ext: assert property (
        s_held(!smartcard_select_i && ck[1]) |-> !sck_oe_o)
        else $error("ext pin driven");
    a_sync_out: assert property (
        s_held(sync_mode_i && !smartcard_select_i && !ck[1]) |-> sck_oe_o)
        else $error("sync no clock");
    a_sc_fixed: assert property (
        s_held(smartcard_select_i && guard_clock_mode_i && !ck[0])
        |-> sck_oe_o && sck_o == ck[1]) else $error("fixed level bad");
endmodule

bind spcs_serial_port spcs_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sync_mode_i(sync_mode_i),
    .smartcard_select_i(smartcard_select_i),
    .guard_clock_mode_i(guard_clock_mode_i), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .tx_empty_irq_o(tx_empty_irq_o),
    .rx_full_irq_o(rx_full_irq_o), .rx_error_irq_o(rx_error_irq_o),
    .tx_done_irq_o(tx_done_irq_o));

/* spcs_remote.sv */
// remote serial transceiver facing the line pins
`timescale 1ns/10ps
module spcs_remote #(
    parameter int BIT = 16
) (
    input  logic       clk_i,
    input  logic       sck_run_i,
    input  logic       txd_i,
    output logic       rxd_o,
    output logic       sck_o,
    output logic [7:0] byte_o,
    output logic       got_o
);
    logic [7:0] sh;
    int         k;
    // link clock toggles only while enabled
    initial begin
        rxd_o = 1'b1;
        byte_o = 8'h00;
        got_o = 1'b0;
        sck_o = 1'b0;
        #3;
        forever #40 sck_o = sck_run_i & ~sck_o;
    end
    // frame: start, data lsb first, optional bit, one stop
    task automatic send(input logic [7:0] d, input logic xe,
                        input logic xv, input logic sv);
        logic [10:0] f;
        int          i;
        f = {sv, xv, d, 1'b0};
        for (i = 0; i < 11; i++) begin
            if (i != 9 || xe) begin
                rxd_o <= f[i];
                repeat (BIT) @(posedge clk_i);
            end
        end
        // a zero stop bit is followed by an idle line again
        if (!sv) begin
            rxd_o <= 1'b1;
            @(posedge clk_i);
        end
    endtask
    // samples the device's serial output at mid bit
    always begin
        @(negedge txd_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (k = 0; k < 8; k++) begin
            repeat (BIT) @(posedge clk_i);
            sh[k] = txd_i;
        end
        repeat (BIT) @(posedge clk_i);
        byte_o <= sh;
        got_o <= 1'b1;
        @(posedge clk_i);
        got_o <= 1'b0;
    end
endmodule

/* tb_serial_port_control_status.sv */
// testbench of the serial port control block
`timescale 1ns/10ps
module tb_serial_port_control_status;
    logic       clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sck_run = 0;
    logic       sync_i = 0, pe_i = 0, mp_i = 0, sc_i = 0, gm_i = 0;
    logic       dtw_i = 0, drr_i = 0, rd_seen = 0;
    logic [1:0] addr_i = 0;
    logic [7:0] wdata_i = 0, dtd_i = 0, d;
    logic [31:0] sd = 32'h9FD1DDE5;
    logic [7:0] rq_e[$], rq_m[$], txq[$];
    int         err_total = 0, n_tests = 0, k;
    wire  [7:0] rdata_o, bq;
    wire        rxd, txd, sck_far, sck_o, sck_oe, got;
    wire        ti, ri, ei, di;
    wire        sck_pin = sck_oe ? sck_o : sck_far;
    always #4 clk_i = ~clk_i;
    spcs_serial_port DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sync_mode_i(sync_i), .chr7_i(1'b0), .par_en_i(pe_i),
        .par_odd_i(1'b0), .stop2_i(1'b0), .mp_mode_i(mp_i),
        .smartcard_select_i(sc_i), .guard_clock_mode_i(gm_i),
        .dma_tx_wr_i(dtw_i), .dma_tx_data_i(dtd_i), .dma_rx_rd_i(drr_i),
        .rxd_i(rxd), .txd_o(txd), .sck_i(sck_pin), .sck_o(sck_o),
        .sck_oe_o(sck_oe), .tx_empty_irq_o(ti), .rx_full_irq_o(ri),
        .rx_error_irq_o(ei), .tx_done_irq_o(di));
    spcs_remote u_far (.clk_i(clk_i), .sck_run_i(sck_run), .txd_i(txd),
        .rxd_o(rxd), .sck_o(sck_far), .byte_o(bq), .got_o(got));
    function automatic logic [7:0] nb();
        sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
        return sd[7:0];
    endfunction
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task test_done();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        rq_e.push_back(e);
        rq_m.push_back(m);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    task clr();
        rd(2'h1, 8'h00, 8'h00);
        wr(2'h1, 8'h00);
    endtask
    task automatic wt(input int w);
        for (int i = 0; i < 4000; i++) begin
            @(posedge clk_i);
            if ((w == 0 && ri === 1'b1) || (w == 1 && txq.size() == 0) ||
                (w == 3 && ei === 1'b1) || (w == 4 && di === 1'b1))
                return;
        end
        err_total++;
        $display("CHECK FAILED wait %0d expected 1 seen 0", w);
        test_done();
    endtask
    // compares read data and bytes seen by the far side
    always @(posedge clk_i) begin
        if (rd_seen) begin
            chk("rdata", rdata_o & rq_m[0], rq_e[0] & rq_m[0]);
            void'(rq_e.pop_front());
            void'(rq_m.pop_front());
        end
        rd_seen <= rd_i;
        if (got) begin
            chk("txbyte", bq, txq.pop_front());
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(2'h1, 8'h84, 8'hFF);
        wr(2'h1, 8'hFF);
        rd(2'h1, 8'h85, 8'hFF);
        wr(2'h1, 8'h00);
        rd(2'h1, 8'h84, 8'hFF);
        $display("test reset_flags done");
        wr(2'h0, 8'h50);
        d = nb();
        u_far.send(d, 0, 0, 1);
        wt(0);
        rd(2'h1, 8'h40, 8'h78);
        u_far.send(nb(), 0, 0, 1);
        wt(3);
        rd(2'h1, 8'h60, 8'h78);
        wr(2'h0, 8'h40);
        rd(2'h1, 8'h60, 8'h78);
        rd(2'h3, d, 8'hFF);
        clr();
        rd(2'h1, 8'h00, 8'h78);
        $display("test overrun done");
        for (k = 0; k < 2; k++) begin
            pe_i <= k[0];
            wr(2'h0, 8'h50);
            d = nb();
            u_far.send(d, k[0], ~^d, k[0]);
            wt(3);
            rd(2'h1, k ? 8'h08 : 8'h10, 8'h78);
            rd(2'h3, d, 8'hFF);
            clr();
            wr(2'h0, 8'h00);
        end
        pe_i <= 1'b0;
        $display("test rx_errors done");
        mp_i <= 1'b1;
        wr(2'h0, 8'h58);
        u_far.send(nb(), 1, 0, 1);
        d = nb();
        u_far.send(d, 1, 1, 1);
        wt(0);
        rd(2'h1, 8'h42, 8'h7A);
        rd(2'h3, d, 8'hFF);
        rd(2'h0, 8'h50, 8'hFF);
        @(posedge clk_i) drr_i <= 1'b1;
        @(posedge clk_i) drr_i <= 1'b0;
        rd(2'h1, 8'h02, 8'h42);
        wr(2'h0, 8'h00);
        mp_i <= 1'b0;
        $display("test multiproc done");
        wr(2'h0, 8'hA4);
        d = nb();
        wr(2'h2, d);
        rd(2'h2, d, 8'hFF);
        chk("txirq", {7'h00, ti}, 8'h01);
        txq.push_back(d);
        clr();
        wt(1);
        wt(4);
        rd(2'h1, 8'h84, 8'h84);
        @(posedge clk_i);
        dtd_i <= nb();
        dtw_i <= 1'b1;
        @(posedge clk_i) dtw_i <= 1'b0;
        txq.push_back(dtd_i);
        wt(1);
        wr(2'h0, 8'h84);
        repeat (4) @(posedge clk_i);
        chk("txirq", {7'h00, ti}, 8'h01);
        chk("doneirq", {7'h00, di}, 8'h01);
        wr(2'h0, 8'h00);
        repeat (2) @(posedge clk_i);
        chk("irqs", {6'h00, ti, di}, 8'h00);
        $display("test transmit done");
        sck_run <= 1'b1;
        for (k = 0; k < 16; k++) begin
            sync_i <= k[2] & ~k[3];
            sc_i <= k[3];
            gm_i <= k[2] & k[3];
            wr(2'h0, {6'h00, k[1:0]});
            repeat (6) @(posedge clk_i);
        end
        sck_run <= 1'b0;
        $display("test clock_pin done");
        repeat (4) @(posedge clk_i);
        test_done();
    end
endmodule
